// File: periodic_timer_10bit_test.sv
`timescale 1ns/100ps
module periodic_timer_10bit_test
   import ptm_pkg::*;
   ;
   logic        clk_in, reset_n_in, rd, wr, waitreq, pin, pin_en, irq, ext_pin, cap_pin;
   logic        hs, sub;
   logic [3:0]  be;
   logic [2:0]  adr;
   logic [31:0] wdat, rdat;
   int          fails, checks, irqs;
   ptm_pin_model pins (.clk_in(clk_in), .ext_count_clk_pin_out(ext_pin), .capture_in_pin_out(cap_pin));
   ptm_timer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .high_speed_clock_in(hs), .sub_clock_in(sub),
      .ext_count_clk_pin_in(ext_pin), .capture_in_pin_in(cap_pin), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(waitreq), .timer_out_pin_out(pin), .timer_out_en_out(pin_en), .timer_irq_out(irq));
   //----------------------------------------
   // Clock, clear-request counter, watchdog
   //----------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (irq === 1'b1) irqs++;
   initial
   begin
      repeat (30000) @(posedge clk_in);
      fails++;
      close_out();
   end
   //----------------------------------------
   // Bus and compare tasks
   //----------------------------------------
   task automatic close_out();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do @(posedge clk_in); while (waitreq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr8(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   //----------------------------------------
   // Scenarios; ctl0 68 run on rising pin edge
   //----------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rchk(3'(i), 8'h00);
      wr8(PTM_IDX_CMPA_L, 8'ha5);
      wr8(PTM_IDX_CMPA_H, 8'hff);
      wr8(PTM_IDX_CMPP_H, 8'hfe);
      be <= 4'he;
      wr8(PTM_IDX_CMPP_L, 8'h77);
      be <= 4'h1;
      rchk(PTM_IDX_CMPP_L, 8'h00);
      wr8(PTM_IDX_CNT_L, 8'h55);
      rchk(PTM_IDX_CMPA_L, 8'ha5);
      rchk(PTM_IDX_CMPA_H, 8'h03);
      rchk(PTM_IDX_CMPP_H, 8'h02);
      rchk(PTM_IDX_CNT_L, 8'h00);
      wr8(PTM_IDX_CMPA_H, 8'h00);
      wr8(PTM_IDX_CMPP_H, 8'h00);
   endtask
   task automatic t_count();
      wr8(PTM_IDX_CTL1, 8'hc0); // Mode set while off
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(5);
      rchk(PTM_IDX_CNT_L, 8'h05);
      wr8(PTM_IDX_CTL0, 8'he8);
      pins.ext_pulses(3);
      rchk(PTM_IDX_CNT_L, 8'h05);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(2);
      rchk(PTM_IDX_CNT_L, 8'h07);
      wr8(PTM_IDX_CTL0, 8'h60);
      pins.ext_pulses(2);
      rchk(PTM_IDX_CNT_L, 8'h07);
      wr8(PTM_IDX_CTL0, 8'h78);
      rchk(PTM_IDX_CNT_L, 8'h00);
      pins.ext_pulses(3);
      rchk(PTM_IDX_CNT_L, 8'h03);
      rchk(PTM_IDX_CNT_H, 8'h00);
      chk(8'(irqs), 8'h00);
      wr8(PTM_IDX_CTL0, 8'h48);
      sub <= 1'b1;
      repeat (6) @(posedge clk_in);
      sub <= 1'b0;
      rchk(PTM_IDX_CNT_L, 8'h09);
   endtask
   task automatic t_clear();
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CMPP_L, 8'h03);
      irqs = 0;
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(4);
      rchk(PTM_IDX_CNT_L, 8'h00);
      chk(8'(irqs), 8'h01);
      chk({7'h00, pin_en}, 8'h00);
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CTL1, 8'hc1);
      wr8(PTM_IDX_CMPA_L, 8'h02);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(3);
      rchk(PTM_IDX_CNT_L, 8'h00);
      chk(8'(irqs), 8'h02);
   endtask
   // Initial level high; invert only with toggle
   task automatic t_compare();
      logic [1:0] f;
      logic       inv;
      for (int i = 0; i < 4; i++)
      begin
         f = 2'(i);
         inv = (f == 2'h3);
         wr8(PTM_IDX_CTL0, 8'h60);
         wr8(PTM_IDX_CTL1, {2'h0, f, 1'b1, inv, 2'h1}); // Changed only while off
         wr8(PTM_IDX_CTL0, 8'h68);
         repeat (4) @(posedge clk_in);
         chk({7'h00, pin}, {7'h00, ~inv});
         pins.ext_pulses(3);
         chk({7'h00, pin}, {7'h00, ~f[0] ^ inv});
      end
   endtask
   task automatic t_pwm();
      for (int i = 0; i < 4; i++)
      begin
         wr8(PTM_IDX_CTL0, 8'h60);
         wr8(PTM_IDX_CTL1, {2'h2, 2'(i), 4'h8});
         wr8(PTM_IDX_CTL0, 8'h68);
         repeat (4) @(posedge clk_in);
         chk({7'h00, pin}, 8'(i != 0));
      end
      pins.ext_pulses(3);
      chk({7'h00, pin}, 8'h00);
      rchk(PTM_IDX_CTL0, 8'h60);
   endtask
   task automatic t_capture();
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CMPP_L, 8'h00);
      wr8(PTM_IDX_CMPA_L, 8'h00);
      wr8(PTM_IDX_CTL1, 8'h40);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(4);
      pins.cap_level(1'b1);
      rchk(PTM_IDX_CMPA_L, 8'h04);
      pins.cap_level(1'b0);
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CTL1, 8'h70);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(2);
      pins.cap_level(1'b1);
      rchk(PTM_IDX_CMPA_L, 8'h04);
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CTL1, 8'h50);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(1);
      pins.cap_level(1'b0);
      rchk(PTM_IDX_CMPA_L, 8'h01);
      wr8(PTM_IDX_CTL0, 8'h60);
      wr8(PTM_IDX_CTL1, 8'h52);
      wr8(PTM_IDX_CTL0, 8'h68);
      pins.ext_pulses(2);
      rchk(PTM_IDX_CMPA_L, 8'h02);
   endtask
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial
   begin
      reset_n_in = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 3'h0;
      wdat = 32'h00000000;
      hs = 1'b1;
      sub = 1'b0;
      be = 4'h1;
      fails = 0;
      checks = 0;
      irqs = 0;
      repeat (10) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_count();
      t_clear();
      t_compare();
      t_pwm();
      t_capture();
      close_out();
   end
endmodule

// File: ptm_pin_model.sv
`timescale 1ns/100ps
module ptm_pin_model
(
   input  wire logic clk_in,             // System clock
   output logic      ext_count_clk_pin_out, // External count clock
   output logic      capture_in_pin_out  // Capture trigger
);
   //----------------------------------------
   // Pin drivers, idle low
   //----------------------------------------
   initial
   begin
      ext_count_clk_pin_out = 1'b0;
      capture_in_pin_out    = 1'b0;
   end
   // Each level held four cycles, past the two-stage sync
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         ext_count_clk_pin_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         ext_count_clk_pin_out <= 1'b0;
         repeat (4) @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
   endtask
   task automatic cap_level(input logic v);
      @(posedge clk_in);
      capture_in_pin_out <= v;
      repeat (6) @(posedge clk_in);
   endtask
endmodule

// File: ptm_pkg.sv
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// - Ten-bit counter counts up on active edges
// - Comparators A and P check counter continuously
// - Run rising clears counter; falling keeps value
// - Run low stops counting, timer off
// - Pause freezes counter; clearing pause resumes
// - Three-bit field selects counting clock source
// - Run rising loads output initial level in compare and PWM modes
// - Two-bit mode: compare, capture, PWM, timer
// - Compare A match: none, low, high, toggle
// - PWM field: inactive, active, PWM, single pulse
// - Capture edge: rising, falling, both, disabled
// - Capture source: capture pin or clock pin
// - Output control: initial level or active polarity
// - Polarity bit inverts output, not timer mode
// - Match requesting present level changes nothing
// - Clear on A match, else P or overflow; single pulse here has no automatic clear
// - Clear select ignored in PWM, pulse, capture
// - Counter readable as low and high bytes
// - Compare values in read/write byte pairs
// - Automatic counter clear raises interrupt request
package ptm_pkg;

   //------------------------------------------------------------
   // Register word offsets (byte addresses are four times these)
   //------------------------------------------------------------
   localparam logic [2:0] PTM_IDX_CTL0  = 3'h0;
   localparam logic [2:0] PTM_IDX_CTL1  = 3'h1;
   localparam logic [2:0] PTM_IDX_CNT_L = 3'h2;
   localparam logic [2:0] PTM_IDX_CNT_H = 3'h3;
   localparam logic [2:0] PTM_IDX_CMPA_L = 3'h4;
   localparam logic [2:0] PTM_IDX_CMPA_H = 3'h5;
   localparam logic [2:0] PTM_IDX_CMPP_L = 3'h6;
   localparam logic [2:0] PTM_IDX_CMPP_H = 3'h7;

   //------------------------------------------------------------
   // Field positions
   //------------------------------------------------------------
   localparam int PTM_C0_PAUSE   = 7;
   localparam int PTM_C0_CLK_HI  = 6;
   localparam int PTM_C0_CLK_LO  = 4;
   localparam int PTM_C0_RUN     = 3;
   localparam int PTM_C1_MODE_HI = 7;
   localparam int PTM_C1_MODE_LO = 6;
   localparam int PTM_C1_FUNC_HI = 5;
   localparam int PTM_C1_FUNC_LO = 4;
   localparam int PTM_C1_LEVEL   = 3;
   localparam int PTM_C1_INVERT  = 2;
   localparam int PTM_C1_CAPSRC  = 1;
   localparam int PTM_C1_CLRSRC  = 0;

   //------------------------------------------------------------
   // Reset values
   //------------------------------------------------------------
   localparam logic [7:0] PTM_CTL0_RST = 8'h00;
   localparam logic [7:0] PTM_CTL1_RST = 8'h00;
   localparam logic [9:0] PTM_CMP_RST  = 10'h000;
   localparam logic [9:0] PTM_CNT_RST  = 10'h000;

   //------------------------------------------------------------
   // Modes and encodings
   //------------------------------------------------------------
   localparam logic [1:0] PTM_MODE_CMP   = 2'h0;
   localparam logic [1:0] PTM_MODE_CAP   = 2'h1;
   localparam logic [1:0] PTM_MODE_PWM   = 2'h2;
   localparam logic [1:0] PTM_MODE_TIMER = 2'h3;

   localparam logic [2:0] PTM_CLK_SYS4  = 3'h0;
   localparam logic [2:0] PTM_CLK_SYS   = 3'h1;
   localparam logic [2:0] PTM_CLK_H16   = 3'h2;
   localparam logic [2:0] PTM_CLK_H64   = 3'h3;
   localparam logic [2:0] PTM_CLK_SUB0  = 3'h4;
   localparam logic [2:0] PTM_CLK_SUB1  = 3'h5;
   localparam logic [2:0] PTM_CLK_EXT_R = 3'h6;
   localparam logic [2:0] PTM_CLK_EXT_F = 3'h7;

   // Prescaler divide counts
   localparam logic [5:0] PTM_DIV4_LAST  = 6'h03;
   localparam logic [5:0] PTM_DIV16_LAST = 6'h0f;
   localparam logic [5:0] PTM_DIV64_LAST = 6'h3f;

   // Single-cycle bus answer (waitrequest low after one wait state)
   localparam logic PTM_WAIT_ONE = 1'b1;

endpackage

// File: ptm_timer.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module ptm_timer
   import ptm_pkg::*;
#(
   parameter int CNT_W = 10
)
(
   input  wire logic        clk_in,             // 25 MHz system clock
   input  wire logic        reset_n_in,         // Async active-low reset
   input  wire logic        high_speed_clock_in, // Tick strobe of the high-speed clock
   input  wire logic        sub_clock_in,       // Tick strobe of the sub clock
   input  wire logic        ext_count_clk_pin_in, // External counting clock pin
   input  wire logic        capture_in_pin_in,  // Capture input pin
   input  wire logic [2:0]  avs_address_in,     // Word address
   input  wire logic        avs_read_in,        // Read request
   input  wire logic        avs_write_in,       // Write request
   input  wire logic [31:0] avs_writedata_in,   // Write data
   input  wire logic [3:0]  avs_byteenable_in,  // Byte enables
   output logic [31:0]      avs_readdata_out,   // Read data
   output logic             avs_waitrequest_out, // Wait request
   output logic             timer_out_pin_out,  // Timer output pin
   output logic             timer_out_en_out,   // Output pin enable
   output logic             timer_irq_out       // Counter auto-clear request pulse
);

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   logic [7:0]       ctl0_q;          // Control 0
   logic [7:0]       ctl1_q;          // Control 1
   logic [CNT_W-1:0] compare_a_value_q; // Compare A
   logic [CNT_W-1:0] compare_p_value_q; // Compare P
   logic [CNT_W-1:0] cnt_q;           // Counter
   logic             run_prev_q;      // Run bit last cycle
   logic             out_q;           // Output level before inversion
   logic [2:0]       ext_sync_q;      // Clock pin sync plus history
   logic [2:0]       cap_sync_q;      // Capture pin sync plus history
   logic [5:0]       pre_q;           // Prescaler
   logic             ack_q;           // Bus answer phase

   // Field aliases
   logic             pause_ctl;
   logic [2:0]       count_clk_sel;
   logic             run_ctl;
   logic [1:0]       op_mode_sel;
   logic [1:0]       pin_func_sel;
   logic             out_level_ctl;
   logic             out_invert;
   logic             capture_src_sel;
   logic             clear_src_sel;

   assign pause_ctl       = ctl0_q[PTM_C0_PAUSE];
   assign count_clk_sel   = ctl0_q[PTM_C0_CLK_HI:PTM_C0_CLK_LO];
   assign run_ctl         = ctl0_q[PTM_C0_RUN];
   assign op_mode_sel     = ctl1_q[PTM_C1_MODE_HI:PTM_C1_MODE_LO];
   assign pin_func_sel    = ctl1_q[PTM_C1_FUNC_HI:PTM_C1_FUNC_LO];
   assign out_level_ctl   = ctl1_q[PTM_C1_LEVEL];
   assign out_invert      = ctl1_q[PTM_C1_INVERT];
   assign capture_src_sel = ctl1_q[PTM_C1_CAPSRC];
   assign clear_src_sel   = ctl1_q[PTM_C1_CLRSRC];

   //------------------------------------------------------------
   // Pin synchronisers and edge detection
   //------------------------------------------------------------
   // Stage 0 feeds only stage 1; edges come from stages 1 and 2
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ext_sync_q <= 3'h0;
         cap_sync_q <= 3'h0;
      end
      else
      begin
         ext_sync_q <= {ext_sync_q[1:0], ext_count_clk_pin_in};
         cap_sync_q <= {cap_sync_q[1:0], capture_in_pin_in};
      end
   end

   logic ext_rise;   // Clock pin rising edge
   logic ext_fall;   // Clock pin falling edge
   logic trig_rise;  // Capture trigger rising edge
   logic trig_fall;  // Capture trigger falling edge
   assign ext_rise  = ext_sync_q[1] & ~ext_sync_q[2];
   assign ext_fall  = ~ext_sync_q[1] & ext_sync_q[2];
   assign trig_rise = capture_src_sel ? ext_rise
                                      : (cap_sync_q[1] & ~cap_sync_q[2]);
   assign trig_fall = capture_src_sel ? ext_fall
                                      : (~cap_sync_q[1] & cap_sync_q[2]);

   //------------------------------------------------------------
   // Counting clock selection
   //------------------------------------------------------------
   // Free prescaler on the system clock; held in reset while off to save power
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         pre_q <= 6'h00;
      else if (!run_ctl)
         pre_q <= 6'h00;
      else
         pre_q <= pre_q + 6'h01;
   end

   logic count_tick;   // One active edge of the counting clock
   always_comb
   begin
      case (count_clk_sel)
         PTM_CLK_SYS4:  count_tick = (pre_q[1:0] == PTM_DIV4_LAST[1:0]);
         PTM_CLK_SYS:   count_tick = 1'b1;
         // High-clock ticks are gated by the prescaler; the high clock strobe
         // must be no slower than the divided rate for an exact ratio
         PTM_CLK_H16:   count_tick = high_speed_clock_in & (pre_q[3:0] == PTM_DIV16_LAST[3:0]);
         PTM_CLK_H64:   count_tick = high_speed_clock_in & (pre_q == PTM_DIV64_LAST);
         PTM_CLK_SUB0,
         PTM_CLK_SUB1:  count_tick = sub_clock_in;
         PTM_CLK_EXT_R: count_tick = ext_rise;
         PTM_CLK_EXT_F: count_tick = ext_fall;
         default:       count_tick = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // Comparators and clear logic
   //------------------------------------------------------------
   logic             match_a;     // Comparator A hit on this tick
   logic             match_p;     // Comparator P hit on this tick
   logic             overflow;    // Counter wraps on this tick
   logic             running;     // Counter advances this cycle
   logic             is_pwm;      // PWM or single-pulse mode
   logic             single;      // Single-pulse submode
   logic             auto_clr;    // Automatic counter clear
   logic             run_rise;    // Run bit low-to-high

   assign running  = run_ctl & run_prev_q & ~pause_ctl & count_tick;
   assign run_rise = run_ctl & ~run_prev_q;
   assign is_pwm   = (op_mode_sel == PTM_MODE_PWM);
   assign single   = is_pwm & (pin_func_sel == 2'h3);
   // Compare on the count about to be left, so the clear happens at the match
   assign match_a  = running & (cnt_q == compare_a_value_q);
   assign match_p  = running & (cnt_q == compare_p_value_q);
   assign overflow = running & (&cnt_q);

   always_comb
   begin
      // Clear select only matters in compare and timer modes
      if ((op_mode_sel == PTM_MODE_CMP || op_mode_sel == PTM_MODE_TIMER) && clear_src_sel)
         auto_clr = match_a;
      else if (single)
         auto_clr = 1'b0;
      else
         auto_clr = (compare_p_value_q == PTM_CMP_RST) ? overflow : match_p;
   end

   //------------------------------------------------------------
   // Counter
   //------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cnt_q      <= PTM_CNT_RST;
         run_prev_q <= 1'b0;
      end
      else
      begin
         run_prev_q <= run_ctl;
         if (run_rise)
            cnt_q <= PTM_CNT_RST;
         else if (auto_clr)
            cnt_q <= PTM_CNT_RST;
         else if (running)
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Interrupt request pulse on each automatic clear
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         timer_irq_out <= 1'b0;
      else
         timer_irq_out <= auto_clr & ~run_rise;
   end

   //------------------------------------------------------------
   // Output pin logic
   //------------------------------------------------------------
   logic pwm_active;   // Duty portion of the PWM period
   assign pwm_active = (cnt_q < compare_a_value_q);

   // Level before polarity inversion
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         out_q <= 1'b0;
      else if (run_rise && op_mode_sel != PTM_MODE_CAP && op_mode_sel != PTM_MODE_TIMER)
         out_q <= out_level_ctl;
      else if (op_mode_sel == PTM_MODE_CMP)
      begin
         if (match_a)
         begin
            case (pin_func_sel)
               2'h1:    out_q <= 1'b0;        // Same level as now: no change
               2'h2:    out_q <= 1'b1;
               2'h3:    out_q <= ~out_q;
               default: out_q <= out_q;
            endcase
         end
      end
      else if (is_pwm)
      begin
         case (pin_func_sel)
            2'h0:    out_q <= ~out_level_ctl;
            2'h1:    out_q <= out_level_ctl;
            2'h2:    out_q <= run_ctl ? (pwm_active ? out_level_ctl : ~out_level_ctl)
                                      : ~out_level_ctl;
            default: out_q <= (run_ctl && !match_a) ? out_level_ctl : ~out_level_ctl;
         endcase
      end
   end

   // Registered pin drive; enable off in timer and capture modes, inversion skipped in timer mode only
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         timer_out_pin_out <= 1'b0;
         timer_out_en_out  <= 1'b0;
      end
      else
      begin
         timer_out_en_out  <= (op_mode_sel != PTM_MODE_TIMER) && (op_mode_sel != PTM_MODE_CAP);
         timer_out_pin_out <= (op_mode_sel == PTM_MODE_TIMER) ? 1'b0
                                                              : (out_q ^ out_invert);
      end
   end

   //------------------------------------------------------------
   // Register writes, capture and single-pulse self clear
   //------------------------------------------------------------
   logic wr_go;    // Write takes effect
   logic capture;  // Capture event
   assign wr_go = avs_write_in & ack_q;

   always_comb
   begin
      case (pin_func_sel)
         2'h0:    capture = trig_rise;
         2'h1:    capture = trig_fall;
         2'h2:    capture = trig_rise | trig_fall;
         default: capture = 1'b0;
      endcase
      capture = capture & run_ctl & (op_mode_sel == PTM_MODE_CAP);
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ctl0_q <= PTM_CTL0_RST;
      else if (single && match_a)
         ctl0_q[PTM_C0_RUN] <= 1'b0;         // Pulse ends; beats a same-cycle write
      else if (single && !run_ctl && ext_rise)
         ctl0_q[PTM_C0_RUN] <= 1'b1;         // Clock pin triggers a pulse
      else if (wr_go && avs_address_in == PTM_IDX_CTL0 && avs_byteenable_in[0])
         ctl0_q <= {avs_writedata_in[7:3], 3'h0};
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ctl1_q <= PTM_CTL1_RST;
      else if (wr_go && avs_address_in == PTM_IDX_CTL1 && avs_byteenable_in[0])
         ctl1_q <= avs_writedata_in[7:0];    // Mode changes expected only while off
   end

   // Compare A: capture wins over a software write in the same cycle
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         compare_a_value_q <= PTM_CMP_RST;
      else if (capture)
         compare_a_value_q <= cnt_q;
      else if (wr_go && avs_byteenable_in[0] && avs_address_in == PTM_IDX_CMPA_L)
         compare_a_value_q[7:0] <= avs_writedata_in[7:0];
      else if (wr_go && avs_byteenable_in[0] && avs_address_in == PTM_IDX_CMPA_H)
         compare_a_value_q[CNT_W-1:8] <= avs_writedata_in[CNT_W-9:0];
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         compare_p_value_q <= PTM_CMP_RST;
      else if (wr_go && avs_byteenable_in[0] && avs_address_in == PTM_IDX_CMPP_L)
         compare_p_value_q[7:0] <= avs_writedata_in[7:0];
      else if (wr_go && avs_byteenable_in[0] && avs_address_in == PTM_IDX_CMPP_H)
         compare_p_value_q[CNT_W-1:8] <= avs_writedata_in[CNT_W-9:0];
   end

   //------------------------------------------------------------
   // Avalon-MM slave: one wait state, then answer
   //------------------------------------------------------------
   // The fixed wait state lets read data come straight from a flip-flop
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         avs_waitrequest_out <= PTM_WAIT_ONE;
      else
         avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_q);
   end

   logic [7:0] rd_byte;   // Selected register
   always_comb
   begin
      case (avs_address_in)
         PTM_IDX_CTL0:   rd_byte = ctl0_q;
         PTM_IDX_CTL1:   rd_byte = ctl1_q;
         PTM_IDX_CNT_L:  rd_byte = cnt_q[7:0];
         PTM_IDX_CNT_H:  rd_byte = {6'h00, cnt_q[CNT_W-1:8]};
         PTM_IDX_CMPA_L: rd_byte = compare_a_value_q[7:0];
         PTM_IDX_CMPA_H: rd_byte = {6'h00, compare_a_value_q[CNT_W-1:8]};
         PTM_IDX_CMPP_L: rd_byte = compare_p_value_q[7:0];
         PTM_IDX_CMPP_H: rd_byte = {6'h00, compare_p_value_q[CNT_W-1:8]};
         default:        rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         avs_readdata_out <= 32'h0000_0000;
      else if (avs_read_in && !ack_q)
         avs_readdata_out <= {24'h00_0000, rd_byte};
   end

endmodule

// File: ptm_timer_chk.sv
`timescale 1ns/100ps
module ptm_timer_chk
   import ptm_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic [2:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        timer_out_pin_out,
   input wire logic        timer_out_en_out,
   input wire logic        timer_irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   //----------------------------------------
   // Shadow of mode and run, from bus writes
   //----------------------------------------
   logic       acc;    // Accepted byte-0 write
   logic [1:0] mode_q; // Last mode written
   logic [1:0] age_q;  // Cycles since mode write
   logic       run_q;  // Last run bit written
   assign acc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   // Age lets the registered outputs settle
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
      begin
         mode_q <= 2'h0;
         age_q  <= 2'h0;
      end
      else if (acc && avs_address_in == PTM_IDX_CTL1)
      begin
         mode_q <= avs_writedata_in[7:6];
         age_q  <= 2'h0;
      end
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   // Single pulse may clear run itself; writes only
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
         run_q <= 1'b0;
      else if (acc && avs_address_in == PTM_IDX_CTL0)
         run_q <= avs_writedata_in[3];
   //----------------------------------------
   // Checks
   //----------------------------------------
   a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered after one wait state");
   a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer held longer than one cycle");
   a_idle_wait: assert property (!(avs_read_in || avs_write_in) && $past(!(avs_read_in || avs_write_in))
      |-> avs_waitrequest_out)
      else $error("answer without a request");
   a_read_upper: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_irq_pulse: assert property (timer_irq_out |=> !timer_irq_out)
      else $error("clear request longer than one cycle");
   a_irq_run: assert property (timer_irq_out |-> run_q || $past(run_q))
      else $error("clear request while stopped");
   a_mode_enable: assert property (age_q == 2'h3 |-> timer_out_en_out == !mode_q[0])
      else $error("output enable does not follow mode");
   a_timer_pin: assert property (mode_q == PTM_MODE_TIMER && age_q == 2'h3 |-> $stable(timer_out_pin_out))
      else $error("output pin moved in timer mode");
endmodule
bind ptm_timer ptm_timer_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .timer_out_pin_out(timer_out_pin_out),
   .timer_out_en_out(timer_out_en_out), .timer_irq_out(timer_irq_out));
